// file: src/lec_regs.v
// Purpose: lookup engine control registers with flush sequencing
// Assumes: single clock, AHB-Lite slave, core logic on the same clock
// Notes:   zero wait state slave, all outputs registered
`timescale 1ns/1ns
`default_nettype none
`include "lec_consts.vh"

module lec_regs #(
    parameter NPORTS = 3
) (
    input  wire              clk,                  // system clock
    input  wire              rst,                  // sync reset, active high
    input  wire              hsel,                 // slave select
    input  wire [31:0]       haddr,                // byte address
    input  wire [1:0]        htrans,               // transfer type
    input  wire              hwrite,               // write when high
    input  wire [2:0]        hsize,                // transfer size
    input  wire              hready,               // bus ready
    input  wire [31:0]       hwdata,               // write data
    output reg               hreadyout,            // slave ready
    output reg               hresp,                // always okay
    output reg  [31:0]       hrdata,               // read data
    input  wire              unknown_vid_fwd_en,   // unknown vid forwarding on
    input  wire [47:0]       switch_mac,           // switch mac address
    input  wire [NPORTS-1:0] port_self_filt_en,    // per port self filter enable
    input  wire              rx_valid,             // rx source address valid
    input  wire [47:0]       rx_sa,                // rx source address
    input  wire [NPORTS-1:0] rx_port_onehot,       // rx ingress port
    input  wire [NPORTS-1:0] port_link_up,         // link state from phys
    input  wire              flush_all_done,       // core finished table flush
    input  wire              flush_mstp_done,      // core finished mstp flush
    input  wire              link_flush_done,      // core finished link flush
    output reg               vlan_en,              // vlan mode on
    output reg               drop_invalid_vid,     // drop bad vid frames
    output reg               invalid_vid_to_host,  // send bad vid to host
    output reg  [2:0]        age_count,            // age count for updates
    output reg  [10:0]       aging_time_s,         // aging time in seconds
    output reg               rsvd_mcast_en,        // reserved multicast table
    output reg  [1:0]        table_index_mode,     // 0 direct 1 crc 2 xor
    output reg               unicast_learn_en,     // learning allowed
    output reg               self_addr_drop,       // drop current rx frame
    output reg               mcast_sa_drop,        // drop current rx frame
    output reg               aging_en,             // aging on
    output reg               fast_aging_en,        // fast aging on
    output reg               flush_all_req,        // table flush request
    output reg               flush_mstp_req,       // mstp flush request
    output reg  [1:0]        flush_scope,          // entries to flush
    output reg               link_flush_req,       // link down flush request
    output reg  [NPORTS-1:0] link_flush_ports      // ports to flush
);

    // register storage
    reg [7:0]        ctl_a_ff;
    reg [7:0]        ctl_b_ff;
    reg [7:0]        ctl_c_ff;
    reg [7:0]        age_period_ff;
    reg [7:0]        nxt_ctl_b;

    // bus data phase
    reg              wr_pend_ff;
    reg [`LEC_ADDR_W-1:0] wr_addr_ff;

    // link state synchroniser and flush bookkeeping
    reg [NPORTS-1:0] link_s1_ff;
    reg [NPORTS-1:0] link_s2_ff;
    reg [NPORTS-1:0] link_prev_ff;
    reg [NPORTS-1:0] pend_ff;
    reg [NPORTS-1:0] act_ff;
    reg [NPORTS-1:0] nxt_pend;

    wire [NPORTS-1:0] link_fall;
    wire              addr_take;
    wire              wr_hit_b;
    wire              trig_ok;

    // unmapped addresses decode to 0 and read as zero
    function [31:0] rd_mux;
        input [31:0] a;
        begin
            if (a[31:`LEC_ADDR_W] != 0) begin
                rd_mux = 32'h0;
            end else if (a[`LEC_ADDR_W-1:0] == `LEC_ADDR_CTL_A) begin
                rd_mux = {24'h0, ctl_a_ff};
            end else if (a[`LEC_ADDR_W-1:0] == `LEC_ADDR_CTL_B) begin
                rd_mux = {24'h0, ctl_b_ff};
            end else if (a[`LEC_ADDR_W-1:0] == `LEC_ADDR_CTL_C) begin
                rd_mux = {24'h0, ctl_c_ff};
            end else if (a[`LEC_ADDR_W-1:0] == `LEC_ADDR_AGE_PERIOD) begin
                rd_mux = {24'h0, age_period_ff};
            end else if (a[`LEC_ADDR_W-1:0] == `LEC_ADDR_STATUS) begin
                rd_mux = 32'h0;
                rd_mux[0] = ctl_b_ff[`LEC_B_FLUSH_ALL];
                rd_mux[1] = ctl_b_ff[`LEC_B_FLUSH_MSTP];
                rd_mux[2] = |act_ff;
                rd_mux[`LEC_S_PEND_LO +: NPORTS] = pend_ff;
                rd_mux[`LEC_S_ACT_LO +: NPORTS] = act_ff;
            end else begin
                rd_mux = 32'h0;
            end
        end
    endfunction

    // codes 00 and 11 both mean direct indexing
    function [1:0] index_mode;
        input [1:0] raw;
        begin
            case (raw)
                `LEC_IDX_RAW_CRC: index_mode = `LEC_MODE_CRC;
                `LEC_IDX_RAW_XOR: index_mode = `LEC_MODE_XOR;
                default:          index_mode = `LEC_MODE_DIRECT;
            endcase
        end
    endfunction

    assign addr_take = hsel & hready & (htrans == `LEC_HTRANS_NONSEQ);
    assign wr_hit_b  = wr_pend_ff & (wr_addr_ff == `LEC_ADDR_CTL_B);
    // a trigger with scope none has nothing to flush, so it never starts
    assign trig_ok   = (ctl_c_ff[`LEC_C_SCOPE_LO +: 2] != `LEC_SCOPE_NONE);

    // address phase capture; write lands at the end of the data phase
    always @(posedge clk) begin
        if (rst) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= {`LEC_ADDR_W{1'b0}};
            hrdata     <= 32'h0;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end else begin
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            wr_pend_ff <= addr_take & hwrite & (haddr[31:`LEC_ADDR_W] == 0);
            if (addr_take) begin
                wr_addr_ff <= haddr[`LEC_ADDR_W-1:0];
            end
            if (addr_take & ~hwrite) begin
                hrdata <= rd_mux(haddr);
            end
        end
    end

    // control b: trigger bits are set by writes and cleared by the core
    always @* begin
        nxt_ctl_b = ctl_b_ff;
        if (flush_all_done) begin
            nxt_ctl_b[`LEC_B_FLUSH_ALL] = 1'b0;
        end
        if (flush_mstp_done) begin
            nxt_ctl_b[`LEC_B_FLUSH_MSTP] = 1'b0;
        end
        if (wr_hit_b) begin
            nxt_ctl_b[`LEC_B_LEARN_DIS]  = hwdata[`LEC_B_LEARN_DIS];
            nxt_ctl_b[`LEC_B_SELF_FILT]  = hwdata[`LEC_B_SELF_FILT];
            nxt_ctl_b[`LEC_B_MC_SA_FWD]  = hwdata[`LEC_B_MC_SA_FWD];
            nxt_ctl_b[`LEC_B_AGING_EN]   = hwdata[`LEC_B_AGING_EN];
            nxt_ctl_b[`LEC_B_FAST_AGING] = hwdata[`LEC_B_FAST_AGING];
            nxt_ctl_b[`LEC_B_LINK_FLUSH] = hwdata[`LEC_B_LINK_FLUSH];
            // writing 0 never aborts a running flush; set wins over done
            if (hwdata[`LEC_B_FLUSH_ALL] & trig_ok) begin
                nxt_ctl_b[`LEC_B_FLUSH_ALL] = 1'b1;
            end
            if (hwdata[`LEC_B_FLUSH_MSTP] & trig_ok) begin
                nxt_ctl_b[`LEC_B_FLUSH_MSTP] = 1'b1;
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            ctl_a_ff      <= `LEC_RST_CTL_A;
            ctl_b_ff      <= `LEC_RST_CTL_B;
            ctl_c_ff      <= `LEC_RST_CTL_C;
            age_period_ff <= `LEC_RST_AGE_PERIOD;
        end else begin
            ctl_b_ff <= nxt_ctl_b;
            if (wr_pend_ff) begin
                if (wr_addr_ff == `LEC_ADDR_CTL_A) begin
                    ctl_a_ff <= hwdata[7:0];
                end else if (wr_addr_ff == `LEC_ADDR_CTL_C) begin
                    ctl_c_ff <= hwdata[7:0];
                end else if (wr_addr_ff == `LEC_ADDR_AGE_PERIOD) begin
                    age_period_ff <= hwdata[7:0];
                end
            end
        end
    end

    // link state comes from the phys, not from this clock domain
    always @(posedge clk) begin
        if (rst) begin
            link_s1_ff   <= {NPORTS{1'b0}};
            link_s2_ff   <= {NPORTS{1'b0}};
            link_prev_ff <= {NPORTS{1'b0}};
        end else begin
            link_s1_ff   <= port_link_up;
            link_s2_ff   <= link_s1_ff;
            link_prev_ff <= link_s2_ff;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NPORTS; gi = gi + 1) begin : g_fall
            assign link_fall[gi] = link_prev_ff[gi] & ~link_s2_ff[gi]
                                   & ctl_b_ff[`LEC_B_LINK_FLUSH];
        end
    endgenerate

    // drops gathered while a link flush runs wait for the next round
    always @* begin
        nxt_pend = pend_ff | link_fall;
        if (act_ff == {NPORTS{1'b0}}) begin
            nxt_pend = link_fall;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            pend_ff          <= {NPORTS{1'b0}};
            act_ff           <= {NPORTS{1'b0}};
            link_flush_req   <= 1'b0;
            link_flush_ports <= {NPORTS{1'b0}};
        end else begin
            pend_ff <= nxt_pend;
            if (act_ff == {NPORTS{1'b0}}) begin
                act_ff           <= pend_ff;
                link_flush_req   <= |pend_ff;
                link_flush_ports <= pend_ff;
            end else if (link_flush_done) begin
                act_ff           <= {NPORTS{1'b0}};
                link_flush_req   <= 1'b0;
                link_flush_ports <= {NPORTS{1'b0}};
            end
        end
    end

    // settings and per frame decisions driven to the lookup core
    always @(posedge clk) begin
        if (rst) begin
            vlan_en             <= 1'b0;
            drop_invalid_vid    <= 1'b0;
            invalid_vid_to_host <= 1'b0;
            age_count           <= 3'h0;
            aging_time_s        <= 11'h0;
            rsvd_mcast_en       <= 1'b0;
            table_index_mode    <= `LEC_MODE_DIRECT;
            unicast_learn_en    <= 1'b0;
            self_addr_drop      <= 1'b0;
            mcast_sa_drop       <= 1'b0;
            aging_en            <= 1'b0;
            fast_aging_en       <= 1'b0;
            flush_all_req       <= 1'b0;
            flush_mstp_req      <= 1'b0;
            flush_scope         <= `LEC_SCOPE_NONE;
        end else begin
            vlan_en <= ctl_a_ff[`LEC_A_VLAN_EN];
            // unknown vid forwarding takes the frame out of this decision
            drop_invalid_vid <= ctl_a_ff[`LEC_A_DROP_INV_VID]
                                & ~unknown_vid_fwd_en;
            invalid_vid_to_host <= ~ctl_a_ff[`LEC_A_DROP_INV_VID]
                                   & ~unknown_vid_fwd_en;
            age_count <= ctl_a_ff[`LEC_A_AGE_CNT_LO +: 3];
            aging_time_s <= {3'h0, age_period_ff}
                            * {8'h0, ctl_a_ff[`LEC_A_AGE_CNT_LO +: 3]};
            rsvd_mcast_en <= ctl_a_ff[`LEC_A_RSVD_MC_EN];
            table_index_mode <= index_mode(ctl_a_ff[`LEC_A_INDEX_LO +: 2]);
            unicast_learn_en <= ~ctl_b_ff[`LEC_B_LEARN_DIS];
            self_addr_drop <= rx_valid & ctl_b_ff[`LEC_B_SELF_FILT]
                              & |(rx_port_onehot & port_self_filt_en)
                              & (rx_sa == switch_mac);
            // bit 40 is the group bit of the first address octet
            mcast_sa_drop <= rx_valid & rx_sa[40]
                             & ~ctl_b_ff[`LEC_B_MC_SA_FWD];
            aging_en      <= ctl_b_ff[`LEC_B_AGING_EN];
            fast_aging_en <= ctl_b_ff[`LEC_B_FAST_AGING];
            flush_all_req  <= nxt_ctl_b[`LEC_B_FLUSH_ALL];
            flush_mstp_req <= nxt_ctl_b[`LEC_B_FLUSH_MSTP];
            flush_scope    <= ctl_c_ff[`LEC_C_SCOPE_LO +: 2];
        end
    end

endmodule // lec_regs
`default_nettype wire

// file: include/lec_consts.vh
// Purpose: constants for the lookup engine control register bank
// Assumes: AHB-Lite word access, one register per aligned word
// Notes:   byte address = register index * 4
`ifndef LEC_CONSTS_VH
`define LEC_CONSTS_VH

// register indices and their byte addresses
`define LEC_IDX_CTL_A        12'h310
`define LEC_IDX_CTL_B        12'h311
`define LEC_IDX_CTL_C        12'h312
`define LEC_IDX_AGE_PERIOD   12'h313
`define LEC_IDX_STATUS       12'h320
`define LEC_ADDR_W           14
`define LEC_ADDR_CTL_A       14'h0c40
`define LEC_ADDR_CTL_B       14'h0c44
`define LEC_ADDR_CTL_C       14'h0c48
`define LEC_ADDR_AGE_PERIOD  14'h0c4c
`define LEC_ADDR_STATUS      14'h0c80

// reset values
`define LEC_RST_CTL_A        8'h61
`define LEC_RST_CTL_B        8'h0c
`define LEC_RST_CTL_C        8'h00
`define LEC_RST_AGE_PERIOD   8'h4b

// control a fields
`define LEC_A_VLAN_EN        7
`define LEC_A_DROP_INV_VID   6
`define LEC_A_AGE_CNT_LO     3
`define LEC_A_RSVD_MC_EN     2
`define LEC_A_INDEX_LO       0

// control b fields
`define LEC_B_LEARN_DIS      7
`define LEC_B_SELF_FILT      6
`define LEC_B_FLUSH_ALL      5
`define LEC_B_FLUSH_MSTP     4
`define LEC_B_MC_SA_FWD      3
`define LEC_B_AGING_EN       2
`define LEC_B_FAST_AGING     1
`define LEC_B_LINK_FLUSH     0

// control c fields
`define LEC_C_SCOPE_LO       2

// flush scope codes
`define LEC_SCOPE_NONE       2'h0
`define LEC_SCOPE_DYN        2'h1
`define LEC_SCOPE_STAT       2'h2
`define LEC_SCOPE_BOTH       2'h3

// table index modes as raw codes and as driven to the core
`define LEC_IDX_RAW_CRC      2'h1
`define LEC_IDX_RAW_XOR      2'h2
`define LEC_MODE_DIRECT      2'h0
`define LEC_MODE_CRC         2'h1
`define LEC_MODE_XOR         2'h2

// status fields
`define LEC_S_PEND_LO        8
`define LEC_S_ACT_LO         16

`define LEC_HTRANS_NONSEQ    2'h2
`endif

// file: verif/lec_regs_asserts.sv
// Purpose: port checker for the lookup engine control bank
// Assumes: bound to every lec_regs instance, one clock domain
// Notes:   register contents are unseen, so relations use ports only
`timescale 1ns/1ns
`default_nettype none
module lec_regs_chk #(
    parameter NPORTS = 3
) (
    input wire logic              clk,                 // clock
    input wire logic              rst,                 // sync reset
    input wire logic              unknown_vid_fwd_en,  // vid override
    input wire logic [47:0]       switch_mac,          // own mac
    input wire logic [NPORTS-1:0] port_self_filt_en,   // port filter on
    input wire logic              rx_valid,            // rx strobe
    input wire logic [47:0]       rx_sa,               // rx source
    input wire logic [NPORTS-1:0] rx_port_onehot,      // rx port
    input wire logic              flush_all_done,      // core done
    input wire logic              flush_mstp_done,     // core done
    input wire logic              link_flush_done,     // core done
    input wire logic              drop_invalid_vid,    // drop bad vid
    input wire logic              invalid_vid_to_host, // bad vid to host
    input wire logic [1:0]        table_index_mode,    // index mode
    input wire logic              self_addr_drop,      // self drop
    input wire logic              mcast_sa_drop,       // mcast sa drop
    input wire logic              flush_all_req,       // table flush
    input wire logic              flush_mstp_req,      // mstp flush
    input wire logic [1:0]        flush_scope,         // flush scope
    input wire logic              link_flush_req,      // link flush
    input wire logic [NPORTS-1:0] link_flush_ports     // link ports
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    chk_vid_override: assert property ($past(unknown_vid_fwd_en) |-> !drop_invalid_vid && !invalid_vid_to_host)
        else $error("vid override ignored");
    chk_vid_exclusive: assert property (!(drop_invalid_vid && invalid_vid_to_host))
        else $error("drop and host both set");
    chk_self_cause: assert property (self_addr_drop |-> $past(rx_valid) && $past(rx_sa) == $past(switch_mac)
        && ($past(port_self_filt_en & rx_port_onehot) != 0))
        else $error("self drop without match");
    chk_mcsa_cause: assert property (mcast_sa_drop |-> $past(rx_valid) && $past(rx_sa[40]))
        else $error("mcast drop without mcast source");
    chk_flush_hold: assert property (flush_all_req && !flush_all_done |=> flush_all_req)
        else $error("table flush dropped early");
    chk_mstp_hold: assert property (flush_mstp_req && !flush_mstp_done |=> flush_mstp_req)
        else $error("mstp flush dropped early");
    chk_link_hold: assert property (link_flush_req && !link_flush_done |=> link_flush_req
        && $stable(link_flush_ports))
        else $error("link flush changed before done");
    chk_link_ports: assert property (link_flush_req |-> link_flush_ports != 0)
        else $error("link flush with no port");
    chk_mode_legal: assert property (table_index_mode != 2'h3)
        else $error("illegal index mode");
    chk_scope_set: assert property (flush_all_req || flush_mstp_req |-> flush_scope != 2'h0)
        else $error("flush with empty scope");
endmodule // lec_regs_chk
bind lec_regs lec_regs_chk #(.NPORTS(NPORTS)) i_chk (.clk(clk), .rst(rst), .unknown_vid_fwd_en(unknown_vid_fwd_en),
    .switch_mac(switch_mac), .port_self_filt_en(port_self_filt_en), .rx_valid(rx_valid), .rx_sa(rx_sa),
    .rx_port_onehot(rx_port_onehot), .flush_all_done(flush_all_done), .flush_mstp_done(flush_mstp_done),
    .link_flush_done(link_flush_done), .drop_invalid_vid(drop_invalid_vid),
    .invalid_vid_to_host(invalid_vid_to_host), .table_index_mode(table_index_mode),
    .self_addr_drop(self_addr_drop), .mcast_sa_drop(mcast_sa_drop), .flush_all_req(flush_all_req),
    .flush_mstp_req(flush_mstp_req), .flush_scope(flush_scope), .link_flush_req(link_flush_req),
    .link_flush_ports(link_flush_ports));
`default_nettype wire

// file: verif/tb_top.sv
// Purpose: self-checking bench for the lookup engine control bank
// Assumes: zero wait state slave, hready fed back from hreadyout
// Notes:   random values from a fixed xorshift seed
`timescale 1ns/1ns
`default_nettype none
`include "lec_consts.vh"
module tb_top;
    logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, ufe = 0, rxv = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, r, q, seed = 32'h187c8bde;
    logic [1:0]  htrans = 0, mode, scope;
    logic [47:0] mac = 0, sa = 0;
    logic [2:0]  pfe = 0, rxp = 0, lup = 3'h7, lports, agec;
    logic [10:0] atime;
    logic [7:0]  v, p;
    logic        hro, hresp, fa_done = 0, fm_done = 0, lk_done = 0;
    logic        vlan, dropv, hostv, rsvd, learn, sdrop, mdrop, agen, fast, fa_req, fm_req, lk_req;
    int          err_count = 0, total_checks = 0;
    always #5 clk = ~clk;
    lec_regs i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hro), .hwdata(hwdata), .hreadyout(hro), .hresp(hresp), .hrdata(hrdata),
        .unknown_vid_fwd_en(ufe), .switch_mac(mac), .port_self_filt_en(pfe), .rx_valid(rxv), .rx_sa(sa),
        .rx_port_onehot(rxp), .port_link_up(lup), .flush_all_done(fa_done), .flush_mstp_done(fm_done),
        .link_flush_done(lk_done), .vlan_en(vlan), .drop_invalid_vid(dropv), .invalid_vid_to_host(hostv),
        .age_count(agec), .aging_time_s(atime), .rsvd_mcast_en(rsvd), .table_index_mode(mode),
        .unicast_learn_en(learn), .self_addr_drop(sdrop), .mcast_sa_drop(mdrop), .aging_en(agen),
        .fast_aging_en(fast), .flush_all_req(fa_req), .flush_mstp_req(fm_req), .flush_scope(scope),
        .link_flush_req(lk_req), .link_flush_ports(lports));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [1:0] mode_of(input logic [1:0] raw);
        return (raw == 2'h1) ? `LEC_MODE_CRC : (raw == 2'h2) ? `LEC_MODE_XOR : `LEC_MODE_DIRECT;
    endfunction
    task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one single transfer; the data phase follows the accepted address phase
    task automatic xfer(input logic wr, input logic [13:0] a, input logic [7:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= `LEC_HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {18'h0, a};
        @(posedge clk);
        while (hro !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge clk);
        while (hro !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #50000;
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        settle();
        chk("vlan_en", vlan, 1'b0);
        chk("drop_vid", dropv, 1'b1);
        chk("age_count", agec, 3'h4);
        chk("aging_time", atime, 11'd300);
        chk("index_mode", mode, `LEC_MODE_CRC);
        chk("learn", learn, 1'b1);
        chk("aging_en", agen, 1'b1);
        xfer(0, `LEC_ADDR_CTL_A, 0);
        chk("ctl_a_rst", rd, 32'h61);
        xfer(0, `LEC_ADDR_CTL_B, 0);
        chk("ctl_b_rst", rd, 32'h0c);
        xfer(0, `LEC_ADDR_AGE_PERIOD, 0);
        chk("period_rst", rd, 32'h4b);
        for (int i = 0; i < 8; i++) begin
            r = xs();
            q = xs();
            v = {r[7:2], i[1:0]};
            p = q[7:0];
            xfer(1, `LEC_ADDR_CTL_A, v);
            ufe <= r[8];
            xfer(1, `LEC_ADDR_AGE_PERIOD, p);
            xfer(0, `LEC_ADDR_CTL_A, 0);
            chk("ctl_a", rd, {24'h0, v});
            settle();
            chk("vlan_en", vlan, v[7]);
            chk("drop_vid", dropv, v[6] & !r[8]);
            chk("vid_host", hostv, !v[6] & !r[8]);
            chk("age_count", agec, v[5:3]);
            chk("aging_time", atime, {3'h0, p} * v[5:3]);
            chk("rsvd_mc", rsvd, v[2]);
            chk("index_mode", mode, mode_of(v[1:0]));
        end
        // scope is still empty, so written flush bits must not stick
        for (int i = 0; i < 4; i++) begin
            r = xs();
            xfer(1, `LEC_ADDR_CTL_B, r[7:0]);
            xfer(0, `LEC_ADDR_CTL_B, 0);
            chk("ctl_b", rd, {24'h0, r[7:0] & 8'hcf});
            settle();
            chk("learn", learn, !r[7]);
            chk("aging_en", agen, r[2]);
            chk("fast", fast, r[1]);
        end
        r = xs();
        q = xs();
        @(posedge clk);
        mac <= {r[15:0], q};
        for (int g = 0; g < 2; g++) begin
            xfer(1, `LEC_ADDR_CTL_B, g ? 8'h40 : 8'h08);
            for (int i = 0; i < 6; i++) begin
                r = xs();
                q = xs();
                @(posedge clk);
                sa <= r[0] ? mac : {q[15:0], r};
                pfe <= r[3:1];
                rxp <= 3'h1 << (r[5:4] % 3);
                rxv <= 1'b1;
                @(posedge clk);
                rxv <= 1'b0;
                #1;
                chk("self_drop", sdrop, g && sa == mac && (pfe & rxp) != 0);
                chk("mcsa_drop", mdrop, g && sa[40]);
            end
        end
        xfer(1, `LEC_ADDR_CTL_C, {4'h0, `LEC_SCOPE_DYN, 2'h0});
        xfer(1, `LEC_ADDR_CTL_B, 8'h35);
        #1;
        chk("flush_all", fa_req, 1'b1);
        chk("flush_mstp", fm_req, 1'b1);
        chk("scope", scope, `LEC_SCOPE_DYN);
        xfer(0, `LEC_ADDR_CTL_B, 0);
        chk("ctl_b_busy", rd, 32'h35);
        xfer(0, `LEC_ADDR_STATUS, 0);
        chk("status_busy", rd, 32'h3);
        @(posedge clk);
        fa_done <= 1'b1;
        @(posedge clk);
        fa_done <= 1'b0;
        #1;
        chk("flush_all", fa_req, 1'b0);
        chk("flush_mstp", fm_req, 1'b1);
        xfer(0, `LEC_ADDR_CTL_B, 0);
        chk("ctl_b_done", rd, 32'h15);
        fm_done <= 1'b1;
        @(posedge clk);
        fm_done <= 1'b0;
        #1;
        chk("flush_mstp", fm_req, 1'b0);
        @(posedge clk);
        lup <= 3'h5;
        for (int k = 0; k < 12 && lk_req !== 1'b1; k++) @(posedge clk);
        #1;
        chk("link_req", lk_req, 1'b1);
        chk("link_ports", lports, 3'h2);
        xfer(0, `LEC_ADDR_STATUS, 0);
        chk("status_link", rd, 32'h00020004);
        lk_done <= 1'b1;
        @(posedge clk);
        lk_done <= 1'b0;
        xfer(1, `LEC_ADDR_CTL_B, 8'h14);
        lup <= 3'h1;
        repeat (10) @(posedge clk);
        #1;
        chk("link_off", lk_req, 1'b0);
        xfer(1, 14'h0c50, 8'hff);
        xfer(0, 14'h0c50, 0);
        chk("unmapped", rd, 32'h0);
        chk("hresp", hresp, 1'b0);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
